// [rtl/dfam_defines.vh]
// Constants for the flat request address mapper: widths, order codes,
// register offsets and field positions.
// Assumes inclusion by bare name from the design files only.
`ifndef DFAM_DEFINES_VH
`define DFAM_DEFINES_VH

// Request address and decoded field widths (widest build)
`define DFAM_ADDR_W 32
`define DFAM_ROW_W 16
`define DFAM_COL_W 10
`define DFAM_BANK_W 3
`define DFAM_GRP_W 2
`define DFAM_LR_W 2
`define DFAM_RANK_W 1
`define DFAM_PACK_W 34

// Per-device geometry
`define DFAM_COL_BITS 10
`define DFAM_ROW_BITS_DDR3 16
`define DFAM_ROW_BITS_DDR4 15
`define DFAM_BANK_BITS_DDR3 3
`define DFAM_BANK_BITS_DDR4 2
`define DFAM_GRP_BITS_X16 1
`define DFAM_GRP_BITS_X8 2
`define DFAM_RANK_BITS 1

// Burst-order bits that the controller ignores
`define DFAM_BURST_BITS 3
`define DFAM_MIN_STEP 32'h8

// Address order codes
`define DFAM_ORD_BANK_LOW 3'h0
`define DFAM_ORD_BANK_FIRST 3'h1
`define DFAM_ORD_ROW_THEN_BANK 3'h2
`define DFAM_ORD_STACK_MID 3'h3
`define DFAM_ORD_STACK_HIGH 3'h4
`define DFAM_ORD_SWAP 3'h5

// Register byte offsets
`define DFAM_REG_PROBE 8'h00
`define DFAM_REG_ROWCOL 8'h04
`define DFAM_REG_BANK 8'h08
`define DFAM_REG_CONFIG 8'h0c
`define DFAM_PROBE_RST 32'h0

// Field positions in the read-only registers
`define DFAM_RC_COL_LSB 0
`define DFAM_RC_ROW_LSB 16
`define DFAM_BK_GRP_LSB 0
`define DFAM_BK_BANK_LSB 4
`define DFAM_BK_LR_LSB 8
`define DFAM_BK_RANK_LSB 12
`define DFAM_CF_ORD_LSB 0
`define DFAM_CF_DDR4_BIT 4
`define DFAM_CF_X16_BIT 5
`define DFAM_CF_MULTI_BIT 6
`define DFAM_CF_SH_LSB 8

`endif

// [rtl/dfam_mapper.v]
// Flat request address to DRAM rank, logical rank, row, column, bank and
// bank group splitter, plus a Wishbone probe for software inspection.
// Assumes the request address comes from logic on clk_i; no synchroniser.
//
// Behaviour
// - Build-time order parameter selects how the flat address is split.
// - Three lowest address bits are burst order; useful step is hex 8.
// - DDR4 bank-first: column, row, bank, group, logical rank, rank upward.
// - DDR4 row-then-bank: column, bank, group, row, then logical rank, rank.
// - Rank zero if single rank; logical rank zero when stack height one.
// - Bank-low order: address bits 4:3 feed bank group (x16: group, then bank) or DDR3 bank.
// - Bank-low order: bit 5 upward gives bank and column; then row, logical rank, rank.
// - Stack mid: bank above group, logical rank, column, row, rank above.
// - Stack high: column low plus above bank, logical rank, row, rank.
// - Swap order exchanges one column bit with one bank bit.
// - DDR3 swap: upper bank bits from bit 3, bank bit 0 at 3 plus bank width.
// - DDR3 swap: column from 2:0, one swapped bit, upper field above.
// - DDR4 x16 swap: group at 3, bank bits above group and two higher.
// - DDR4 x16 swap: column from 2:0, bit 5 between the bank bits, field above bank.
`timescale 1ns/1ns
`include "dfam_defines.vh"

module dfam_mapper #(
	parameter MEM_DDR4 = 1,
	parameter DEV_X16 = 0,
	parameter [2:0] ADDR_ORDER = `DFAM_ORD_BANK_LOW,
	parameter RANKS = 1,
	parameter STACK_HEIGHT = 1
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Request address from user logic
	input wire [`DFAM_ADDR_W-1:0] app_addr_i,
	// Decoded fields
	output wire [`DFAM_RANK_W-1:0] rank_o,
	output wire [`DFAM_LR_W-1:0] logical_rank_o,
	output wire [`DFAM_ROW_W-1:0] row_o,
	output wire [`DFAM_COL_W-1:0] col_o,
	output wire [`DFAM_BANK_W-1:0] bank_o,
	output wire [`DFAM_GRP_W-1:0] bank_group_o,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire ack_o
);

////////////////////////////////////////////////////////////////////////////
// Geometry of this build

localparam CW = `DFAM_COL_BITS;
localparam RW = MEM_DDR4 ? `DFAM_ROW_BITS_DDR4 : `DFAM_ROW_BITS_DDR3;
localparam BW = MEM_DDR4 ? `DFAM_BANK_BITS_DDR4 : `DFAM_BANK_BITS_DDR3;
localparam GW = !MEM_DDR4 ? 0 :
	(DEV_X16 ? `DFAM_GRP_BITS_X16 : `DFAM_GRP_BITS_X8);
// Logical rank width collapses to nothing in a planar build
localparam LW = (STACK_HEIGHT == 1) ? 0 :
	(STACK_HEIGHT == 2) ? 1 : 2;
localparam KW = (RANKS == 1) ? 0 : `DFAM_RANK_BITS;
localparam LB = `DFAM_BURST_BITS;

////////////////////////////////////////////////////////////////////////////
// Field extraction helper

// Width zero yields zero, which covers absent group or logical rank
function [31:0] fld;
	input [31:0] a;
	input integer lsb;
	input integer w;
	begin
		fld = (a >> lsb) & ((32'h1 << w) - 32'h1);
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// Address split, one branch per build-time order

function [`DFAM_PACK_W-1:0] decode;
	input [31:0] a;
	reg [31:0] rk;
	reg [31:0] lr;
	reg [31:0] row;
	reg [31:0] col;
	reg [31:0] bank;
	reg [31:0] grp;
	reg [31:0] low;
	begin
		rk = 32'h0;
		lr = 32'h0;
		row = 32'h0;
		col = 32'h0;
		bank = 32'h0;
		grp = 32'h0;
		// Burst-order bits pass through untouched to the column
		low = fld(a, 0, LB);
		case (ADDR_ORDER)
		`DFAM_ORD_BANK_FIRST: begin
			col = fld(a, 0, CW);
			row = fld(a, CW, RW);
			bank = fld(a, CW + RW, BW);
			grp = fld(a, CW + RW + BW, GW);
			lr = fld(a, CW + RW + BW + GW, LW);
			rk = fld(a, CW + RW + BW + GW + LW, KW);
		end
		`DFAM_ORD_ROW_THEN_BANK: begin
			col = fld(a, 0, CW);
			bank = fld(a, CW, BW);
			grp = fld(a, CW + BW, GW);
			row = fld(a, CW + BW + GW, RW);
			lr = fld(a, CW + RW + BW + GW, LW);
			rk = fld(a, CW + RW + BW + GW + LW, KW);
		end
		`DFAM_ORD_STACK_MID: begin
			grp = fld(a, LB, GW);
			bank = fld(a, LB + GW, BW);
			lr = fld(a, LB + BW + GW, LW);
			col = (fld(a, LB + LW + BW + GW, CW - LB) << LB) | low;
			row = fld(a, CW + LW + BW + GW, RW);
			rk = fld(a, RW + CW + LW + BW + GW, KW);
		end
		`DFAM_ORD_STACK_HIGH: begin
			grp = fld(a, LB, GW);
			bank = fld(a, LB + GW, BW);
			col = (fld(a, LB + BW + GW, CW - LB) << LB) | low;
			lr = fld(a, CW + BW + GW, LW);
			row = fld(a, LW + CW + BW + GW, RW);
			rk = fld(a, RW + LW + CW + BW + GW, KW);
		end
		`DFAM_ORD_SWAP: begin
			row = fld(a, GW + BW + CW, RW);
			rk = fld(a, CW + RW + BW + GW, KW);
			if (!MEM_DDR4) begin
				// Upper bank bits at 3 upward, bank bit 0 moved up one
				bank = (fld(a, LB, BW - 1) << 1) |
					fld(a, LB + BW, 1);
				col = (fld(a, LB + BW + 1, CW - 4) << 4) |
					(fld(a, LB + BW - 1, 1) << LB) | low;
			end else if (DEV_X16) begin
				grp = fld(a, LB, GW);
				bank = (fld(a, LB + GW + 2, BW - 1) << (BW - 1)) |
					fld(a, LB + GW, BW - 1);
				col = (fld(a, LB + GW + BW + 1, CW - 4) << 4) |
					(fld(a, LB + GW + 1, 1) << LB) | low;
			end else begin
				// x4 and x8 parts swap the bit just above the group
				grp = fld(a, LB, GW);
				bank = fld(a, LB + GW + 1, BW);
				col = (fld(a, LB + GW + BW + 1, CW - 4) << 4) |
					(fld(a, LB + GW, 1) << LB) | low;
			end
		end
		default: begin
			// Bank-low order, the recommended one for linear streams
			row = fld(a, GW + BW + CW, RW);
			lr = fld(a, GW + BW + CW + RW, LW);
			rk = fld(a, GW + BW + CW + RW + LW, KW);
			col = (fld(a, LB + GW + BW, CW - LB) << LB) | low;
			if (MEM_DDR4) begin
				grp = fld(a, LB, GW);
				bank = fld(a, LB + GW, BW);
			end else begin
				// Bits 4:3 on the high bank bits, bit 5 on bank bit 0
				bank = (fld(a, LB, BW - 1) << 1) |
					fld(a, LB - 1 + BW, 1);
			end
		end
		endcase
		if (RANKS == 1) begin
			rk = 32'h0;
		end
		if (STACK_HEIGHT == 1) begin
			lr = 32'h0;
		end
		decode = {rk[`DFAM_RANK_W-1:0], lr[`DFAM_LR_W-1:0],
			row[`DFAM_ROW_W-1:0], col[`DFAM_COL_W-1:0],
			bank[`DFAM_BANK_W-1:0], grp[`DFAM_GRP_W-1:0]};
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// Live request decode

// No pipeline stage: the scheduler sees the fields with the request
wire [`DFAM_PACK_W-1:0] req_dec;

assign req_dec = decode(app_addr_i);
assign {rank_o, logical_rank_o, row_o, col_o, bank_o, bank_group_o} =
	req_dec;

////////////////////////////////////////////////////////////////////////////
// Software probe: write an address, read back its split

reg [31:0] probe_r;
reg [31:0] dat_r;
reg ack_r;
wire [`DFAM_PACK_W-1:0] probe_dec;
wire [`DFAM_RANK_W-1:0] p_rank;
wire [`DFAM_LR_W-1:0] p_lr;
wire [`DFAM_ROW_W-1:0] p_row;
wire [`DFAM_COL_W-1:0] p_col;
wire [`DFAM_BANK_W-1:0] p_bank;
wire [`DFAM_GRP_W-1:0] p_grp;
wire bus_req;
wire [31:0] byte_mask;
reg [31:0] rd_nxt;
reg [31:0] cfg_word;

assign probe_dec = decode(probe_r);
assign {p_rank, p_lr, p_row, p_col, p_bank, p_grp} = probe_dec;
// Ack is high for exactly one cycle per request
assign bus_req = cyc_i & stb_i & ~ack_r;
assign byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
	{8{sel_i[1]}}, {8{sel_i[0]}}};

always @* begin
	cfg_word = 32'h0;
	cfg_word[`DFAM_CF_ORD_LSB +: 3] = ADDR_ORDER;
	cfg_word[`DFAM_CF_DDR4_BIT] = (MEM_DDR4 != 0);
	cfg_word[`DFAM_CF_X16_BIT] = (DEV_X16 != 0);
	cfg_word[`DFAM_CF_MULTI_BIT] = (RANKS != 1);
	cfg_word[`DFAM_CF_SH_LSB +: 2] = LW[1:0];
end

always @* begin
	rd_nxt = 32'h0;
	case (adr_i)
	`DFAM_REG_PROBE: begin
		rd_nxt = probe_r;
	end
	`DFAM_REG_ROWCOL: begin
		rd_nxt[`DFAM_RC_COL_LSB +: `DFAM_COL_W] = p_col;
		rd_nxt[`DFAM_RC_ROW_LSB +: `DFAM_ROW_W] = p_row;
	end
	`DFAM_REG_BANK: begin
		rd_nxt[`DFAM_BK_GRP_LSB +: `DFAM_GRP_W] = p_grp;
		rd_nxt[`DFAM_BK_BANK_LSB +: `DFAM_BANK_W] = p_bank;
		rd_nxt[`DFAM_BK_LR_LSB +: `DFAM_LR_W] = p_lr;
		rd_nxt[`DFAM_BK_RANK_LSB +: `DFAM_RANK_W] = p_rank;
	end
	`DFAM_REG_CONFIG: begin
		rd_nxt = cfg_word;
	end
	default: begin
		// Unmapped offsets read as zero and still acknowledge
		rd_nxt = 32'h0;
	end
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		ack_r <= 1'b0;
		dat_r <= 32'h0;
		probe_r <= `DFAM_PROBE_RST;
	end else begin
		ack_r <= bus_req;
		if (bus_req && !we_i) begin
			dat_r <= rd_nxt;
		end
		// Only the probe word is writable; writes elsewhere are dropped
		if (bus_req && we_i && adr_i == `DFAM_REG_PROBE) begin
			probe_r <= (probe_r & ~byte_mask) | (dat_i & byte_mask);
		end
	end
end

assign dat_o = dat_r;
assign ack_o = ack_r;

endmodule

// [tb/dfam_app_model.sv]
// Request source model: holds the flat address or steps it by one burst.
// Assumes the bench drives load_i and step_i on rising clk_i edges.
`timescale 1ns/1ns
module dfam_app_model (
	// Clock
	input wire clk_i,
	// Control from the bench
	input wire load_i,
	input wire step_i,
	input wire [31:0] addr_i,
	// Flat request address
	output reg [31:0] app_addr_o
);
	initial app_addr_o = 32'h0;
	// Fastest toggling bit placed at bit 3, burst bits left alone
	always @(posedge clk_i) begin
		if (load_i)
			app_addr_o <= addr_i;
		else if (step_i)
			app_addr_o <= app_addr_o + 32'h8;
	end
endmodule

// [tb/dfam_mapper_checker.sv]
// Port assertions: ack timing for every build, field placement for the default build: DDR4 x8, bank-low order,
// one rank, stack height one.
`timescale 1ns/1ns
module dfam_mapper_checker #(
	// High only where the bound instance is the default build
	parameter ON = 1
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Request decode
	input wire [31:0] app_addr_i,
	input wire [0:0] rank_o,
	input wire [1:0] logical_rank_o,
	input wire [15:0] row_o,
	input wire [9:0] col_o,
	input wire [2:0] bank_o,
	input wire [1:0] bank_group_o,
	// Wishbone
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [31:0] dat_o,
	input wire ack_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = cyc_i && stb_i && !ack_o;
	property p_grp; bank_group_o == app_addr_i[4:3]; endproperty
	property p_bank; bank_o == {1'b0, app_addr_i[6:5]}; endproperty
	property p_col; col_o == {app_addr_i[13:7], app_addr_i[2:0]}; endproperty
	property p_row; row_o == {1'b0, app_addr_i[28:14]}; endproperty
	property p_rank; rank_o == 1'b0 && logical_rank_o == 2'h0; endproperty
	property p_same; $changed(app_addr_i[4:3]) |-> $changed(bank_group_o);
	endproperty
	property p_ack; req |=> ack_o ##1 !ack_o; endproperty
	property p_cfg; req && !we_i && adr_i == 8'h0c |=> dat_o == 32'h10;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");
	// Field placement below only holds for the default build
	if (ON) begin : g_dflt
		a_grp: assert property (p_grp) else $error("group wrong");
		a_bank: assert property (p_bank) else $error("bank wrong");
		a_col: assert property (p_col) else $error("column wrong");
		a_row: assert property (p_row) else $error("row wrong");
		a_rank: assert property (p_rank) else $error("rank not zero");
		a_same: assert property (p_same) else $error("decode late");
		a_cfg: assert property (p_cfg) else $error("order code wrong");
	end
	c_wr: cover property (req && we_i);
	c_grp3: cover property (bank_group_o == 2'h3);
	c_cfg: cover property (req && adr_i == 8'h0c);
endmodule
bind dfam_mapper dfam_mapper_checker #(.ON(MEM_DDR4 == 1 && DEV_X16 == 0 &&
	ADDR_ORDER == 3'h0 && RANKS == 1 && STACK_HEIGHT == 1))
	dfam_mapper_checker_i (.clk_i, .rst_i,
	.app_addr_i, .rank_o, .logical_rank_o, .row_o, .col_o, .bank_o,
	.bank_group_o, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o);

// [tb/tb.sv]
// Self-checking bench for the mapper in its default build and eight other builds.
// Assumes the bound checker and the request model beside the design.
`timescale 1ns/1ns
module tb;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic we_i = 1'b0, load = 1'b1, step = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, addr = 32'hffffffff, app, dat_o, rd;
	wire ack_o;
	wire [0:0] rank_o;
	wire [1:0] logical_rank_o, bank_group_o;
	wire [15:0] row_o;
	wire [9:0] col_o;
	wire [2:0] bank_o;
	wire [33:0] flds = {rank_o, logical_rank_o, row_o, col_o, bank_o,
		bank_group_o};
	int mismatches = 0, n_checks = 0;
	logic [31:0] ra [9] = '{32'h8, 32'h18, 32'h20, 32'h47, 32'h80, 32'h3f80,
		32'h4000, 32'h1fffc000, 32'hffffffff};
	logic [33:0] re [9] = '{34'h1, 34'h3, 34'h4, 34'he8, 34'h100, 34'h7f00,
		34'h8000, 34'h3fff8000, 34'h3fffffef};
	// Other builds: DDR3 bank-low, bank-first, row-then-bank, stack mid,
	// stack high, DDR3 swap, DDR4 x16 swap, DDR4 x8 swap; all two ranks
	localparam bit [7:0] X_DDR4 = 8'hde, X_X16 = 8'h40, X_SH2 = 8'h1e;
	localparam logic [2:0] X_ORD [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
		3'h5, 3'h5, 3'h5};
	wire [33:0] xf [8];
	logic [31:0] xa [4] = '{32'h120, 32'hf8, 32'h6400, 32'h7e000001};
	logic [33:0] xe [4][8] = '{
		'{34'h404, 34'h2400, 34'h2400, 34'h104, 34'h204, 34'h500,
			34'h500, 34'h300},
		'{34'h31c, 34'h1f00, 34'h1f00, 34'h8000000f, 34'h10f, 34'h31c,
			34'h30d, 34'h10f},
		'{34'h19000, 34'hc8000, 34'h8006, 34'h6400, 34'h80004800,
			34'h19000, 34'h19000, 34'hc800},
		'{34'h278000020, 34'h28000002f, 34'h2bc000020, 34'h23e000020,
			34'h23e000020, 34'h278000020, 34'h238000020, 34'h23c000020}};
	always #50 clk_i = ~clk_i;
	dfam_app_model dfam_app_model_i (.clk_i, .load_i(load), .step_i(step),
		.addr_i(addr), .app_addr_o(app));
	dfam_mapper dfam_mapper_i (.clk_i, .rst_i, .app_addr_i(app), .rank_o,
		.logical_rank_o, .row_o, .col_o, .bank_o, .bank_group_o, .cyc_i,
		.stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o);
	for (genvar g = 0; g < 8; g++) begin : bld
		dfam_mapper #(.MEM_DDR4(X_DDR4[g]), .DEV_X16(X_X16[g]),
			.ADDR_ORDER(X_ORD[g]), .RANKS(2),
			.STACK_HEIGHT(X_SH2[g] ? 2 : 1)) dfam_mapper_i (.clk_i, .rst_i,
			.app_addr_i(app), .rank_o(xf[g][33]),
			.logical_rank_o(xf[g][32:31]), .row_o(xf[g][30:15]),
			.col_o(xf[g][14:5]), .bank_o(xf[g][4:2]),
			.bank_group_o(xf[g][1:0]), .cyc_i(1'b0), .stb_i(1'b0),
			.we_i(1'b0), .adr_i(8'h00), .sel_i(4'h0), .dat_i(32'h0),
			.dat_o(), .ack_o());
	end
	////////////////////////////////////////
	task automatic stop_test;
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic cycle, held until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			mismatches++;
			stop_test;
		end else begin
			rd = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, 4'hf);
		chk({2'b00, rd}, {2'b00, exp});
	endtask
	initial begin
		#5000000;
		mismatches++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		chk(flds, 34'h3fffffef);
		chk({ack_o, dat_o}, 34'h0);
		@(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ra[i]) begin
			@(posedge clk_i);
			addr <= ra[i];
			@(posedge clk_i);
			@(negedge clk_i);
			chk(flds, re[i]);
		end
		foreach (xa[r]) begin
			@(posedge clk_i);
			addr <= xa[r];
			@(posedge clk_i);
			@(negedge clk_i);
			for (int b = 0; b < 4; b++)
				chk(xf[b], xe[r][b]);
			for (int b = 4; b < 8; b++)
				chk(xf[b], xe[r][b]);
		end
		@(posedge clk_i);
		addr <= 32'h0;
		@(posedge clk_i);
		load <= 1'b0;
		step <= 1'b1;
		// Eight steps walk all groups twice; the bank moves after four
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_i);
			chk({bank_o, bank_group_o}, i);
		end
		@(posedge clk_i);
		step <= 1'b0;
		rdchk(8'h00, 32'h0);
		wb(1'b1, 8'h00, 32'h1fffffff, 4'hf);
		rdchk(8'h04, 32'h7fff03ff);
		rdchk(8'h08, 32'h33);
		wb(1'b1, 8'h00, 32'h0, 4'h1);
		rdchk(8'h00, 32'h1fffff00);
		wb(1'b1, 8'h04, 32'h0, 4'hf);
		// Low byte cleared above, so column bit 3 is gone as well
		rdchk(8'h04, 32'h7fff03f0);
		rdchk(8'h0c, 32'h10);
		rdchk(8'h40, 32'h0);
		// Reset in mid-run must clear the probe word again
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(8'h00, 32'h0);
		stop_test;
	end
endmodule
